/* File: ext_bus_pkg.sv */
// How it works
// R1: The low address byte sits on the shared lane in period one and data in periods two to four.
// R2: In eight-bit mode a word moves as two byte cycles over the shared lane, low byte first.
// R3: Three unshared address outputs give peripherals a range of at most eight bytes.
// R4: The unshared address outputs float during bus hold or reset.
// R5: The shared address/data lane floats during bus hold or reset.
// R6: The latch strobe pulses while the address is on the lane, and the address holds at its falling edge; the port changes the lane on the same clock edge.
// R7: The latch strobe floats with a weak low during hold, and a software-enabled weak pulldown acts during reset.
// R8: The read strobe asserts for reads only after the lane has been released.
// R9: The read strobe floats during bus hold.
// R10: The write strobe marks data to be written and floats during bus hold or reset.
// R11: The external I/O space is six regions of 256 bytes each.
// R12: A peripheral captures the low address at the latch strobe's falling edge and keeps it for the cycle.
// R13: Each region select asserts with the address on the lane and covers 256 bytes.
package ext_bus_pkg;
    localparam int DATA_W = 8;
    localparam int LOW_ADDR_W = 3;
    localparam int IO_ADDR_W = 16;
    localparam int REGION_COUNT = 6;
    localparam int REGION_BITS = 8;
    localparam logic [IO_ADDR_W-1:0] REGION_BASE_RESET = 16'h0000;
    localparam int SYNC_STAGES = 3;
    typedef enum logic [1:0] {T1, T2, T3, T4} period_t;
endpackage : ext_bus_pkg

/* File: ext_bus_port.sv */
// External bus port: four-period cycles on a shared byte lane.
module ext_bus_port
#(
    parameter int N_REGIONS = ext_bus_pkg::REGION_COUNT
)
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic hold_req_i,
    input wire logic pulldown_en_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic req_word_i,
    input wire logic req_io_i,
    input wire logic [ext_bus_pkg::IO_ADDR_W-1:0] req_addr_i,
    input wire logic [15:0] req_wdata_i,
    input wire logic [ext_bus_pkg::IO_ADDR_W-1:0] region_base_i,
    output logic req_ready_o,
    output logic resp_valid_o,
    output logic [15:0] resp_rdata_o,
    output logic hold_ack_o,
    input wire logic [ext_bus_pkg::DATA_W-1:0] ad_i,
    output logic [ext_bus_pkg::DATA_W-1:0] ad_o,
    output logic ad_oe_o,
    output logic [ext_bus_pkg::LOW_ADDR_W-1:0] addr_o,
    output logic addr_oe_o,
    output logic addr_latch_o,
    output logic addr_latch_oe_o,
    output logic addr_latch_pulldown_o,
    output logic rd_n_o,
    output logic rd_oe_o,
    output logic wr_n_o,
    output logic wr_oe_o,
    output logic [N_REGIONS-1:0] periph_region_select_n_o
);
    import ext_bus_pkg::*;

    // The region index is three bits wide and the I/O space holds six regions, so no more.
    if (N_REGIONS < 1 || N_REGIONS > REGION_COUNT)
    begin : g_bad_regions
        $error("N_REGIONS out of range");
    end

    logic hold_sync;
    logic busy;
    logic second_byte;
    logic holding;
    period_t period;
    logic is_write;
    logic is_word;
    logic is_io;
    logic [IO_ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic [7:0] low_rdata;

    // The hold request comes from a pin, so it is synchronised first.
    pin_sync u_hold_sync
    (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .pin_i(hold_req_i),
        .level_o(hold_sync)
    );

    // Decode: request take, the end of an access and the start of every T1.
    wire start = !busy && !holding && !hold_sync && req_valid_i;
    wire last_byte = !is_word || second_byte;
    wire end_of_access = busy && period == T4 && last_byte;
    wire enter_t1 = start || (busy && period == T4 && !last_byte);
    wire next_holding = hold_sync && (!busy || end_of_access);

    // The high byte of a word lives at the next byte address, so its T1 shows addr + 1.
    wire [IO_ADDR_W-1:0] high_byte_addr = addr + {{(IO_ADDR_W-1){1'b0}}, 1'b1};
    wire [IO_ADDR_W-1:0] cycle_addr = start ? req_addr_i : high_byte_addr;
    wire [7:0] out_byte = second_byte ? wdata[15:8] : wdata[7:0];

    // Regions are decoded from the request itself at take time, so a select falls in T1
    // together with the address instead of one period behind it.
    wire [IO_ADDR_W-1:0] dec_addr = start ? req_addr_i : addr;
    wire dec_io = start ? req_io_i : is_io;
    wire [IO_ADDR_W-1:0] region_off = dec_addr - region_base_i;
    wire in_io_space = region_off < IO_ADDR_W'(N_REGIONS << REGION_BITS);
    wire [2:0] region_idx = 3'(region_off >> REGION_BITS);
    wire [N_REGIONS-1:0] region_hit;

    // One select per region, each covering 256 bytes of I/O space.
    genvar g;
    generate
        for (g = 0; g < N_REGIONS; g++)
        begin : g_region
            assign region_hit[g] = dec_io && in_io_space && region_idx == 3'(g); // see R11
        end
    endgenerate

    // Cycle sequencing: T1 through T4, a word in eight-bit mode takes two cycles.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            busy <= 1'b0;
            second_byte <= 1'b0;
            holding <= 1'b0;
            period <= T1;
            is_write <= 1'b0;
            is_word <= 1'b0;
            is_io <= 1'b0;
            addr <= REGION_BASE_RESET;
            wdata <= 16'h0000;
            low_rdata <= 8'h00;
        end
        else if (clk_en_i)
        begin
            holding <= holding ? hold_sync : next_holding;
            if (start)
            begin
                busy <= 1'b1;
                second_byte <= 1'b0;
                period <= T1;
                is_write <= req_write_i;
                is_word <= req_word_i;
                is_io <= req_io_i;
                addr <= req_addr_i;
                wdata <= req_wdata_i;
            end
            else if (busy)
            begin
                period <= period_t'(period + 2'd1);
                if (period == T4 && !second_byte && !is_write)
                    low_rdata <= ad_i;
                if (period == T4)
                begin
                    second_byte <= !last_byte; // see R2
                    busy <= !last_byte;
                end
            end
        end
    end

    // Output enables follow the hold state, so every pin with an enable floats from the edge hold is granted.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            addr_oe_o <= 1'b0; // see R4
            addr_latch_oe_o <= 1'b0;
            rd_oe_o <= 1'b1;
            wr_oe_o <= 1'b0; // see R10
            hold_ack_o <= 1'b0;
            req_ready_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            addr_latch_oe_o <= !next_holding; // see R7
            addr_oe_o <= !next_holding; // see R4
            rd_oe_o <= !next_holding; // see R9
            wr_oe_o <= !next_holding; // see R10
            hold_ack_o <= next_holding;
            req_ready_o <= !busy && !start && !next_holding;
        end
    end

    // The weak pull on the latch strobe follows the software enable while reset is low, so
    // this flop has no reset of its own; reset is read as a level, and a release close to
    // the edge only shifts the hand-over to the hold pull by one cycle.
    always_ff @(posedge core_clk_i)
    begin
        if (clk_en_i)
            addr_latch_pulldown_o <= resetn_i ? next_holding : pulldown_en_i; // see R7
    end

    // Lane, unshared address and strobes: T1 drives the address, T2 to T4 carry data.
    // Reads leave the lane floating from T2, and the read strobe waits one more period.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ad_o <= 8'h00;
            ad_oe_o <= 1'b0; // see R5
            addr_o <= 3'h0;
            addr_latch_o <= 1'b0;
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
        end
        else if (clk_en_i)
        begin
            addr_latch_o <= 1'b0;
            ad_oe_o <= 1'b0;
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
            if (enter_t1)
            begin
                ad_o <= cycle_addr[7:0]; // see R1
                ad_oe_o <= 1'b1; // see R1
                addr_latch_o <= 1'b1; // see R6
                addr_o <= cycle_addr[LOW_ADDR_W-1:0]; // see R3
            end
            else if (busy && period != T4)
            begin
                ad_o <= out_byte; // see R1
                ad_oe_o <= is_write; // see R5
                rd_n_o <= is_write || period == T1; // see R8
                wr_n_o <= !is_write || period == T3; // see R10
            end
        end
    end

    // Region selects fall with the address in T1 and stay low to the end of the last T4.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            periph_region_select_n_o <= '1;
        else if (clk_en_i)
        begin
            if (enter_t1)
                periph_region_select_n_o <= ~region_hit; // see R13
            else if (end_of_access)
                periph_region_select_n_o <= '1;
        end
    end

    // Completion: one pulse after the last T4, with the byte or word read from the lane.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            resp_valid_o <= 1'b0;
            resp_rdata_o <= 16'h0000;
        end
        else if (clk_en_i)
        begin
            resp_valid_o <= end_of_access;
            if (end_of_access)
                resp_rdata_o <= is_write ? 16'h0000 :
                    (is_word ? {ad_i, low_rdata} : {8'h00, ad_i});
        end
    end
endmodule : ext_bus_port

/* File: ext_bus_port_asserts.sv */
// Timing and float relations of the shared-lane bus port.
module ext_bus_port_asserts
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    input wire logic req_word_i,
    input wire logic req_ready_o,
    input wire logic resp_valid_o,
    input wire logic hold_ack_o,
    input wire logic ad_oe_o,
    input wire logic addr_oe_o,
    input wire logic addr_latch_o,
    input wire logic addr_latch_oe_o,
    input wire logic addr_latch_pulldown_o,
    input wire logic rd_n_o,
    input wire logic rd_oe_o,
    input wire logic wr_oe_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // Every output that the far side may drive must be released while held.
    property p_lane_hold; hold_ack_o |-> !ad_oe_o; endproperty
    a_lane_hold: assert property (p_lane_hold) else $error("lane driven in hold");
    property p_addr_hold; hold_ack_o |-> !addr_oe_o; endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("addr driven in hold");
    property p_latch_hold; hold_ack_o |-> !addr_latch_oe_o && addr_latch_pulldown_o; endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch driven in hold");
    property p_rd_hold; hold_ack_o |-> !rd_oe_o; endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read strobe driven in hold");
    property p_wr_hold; hold_ack_o |-> !wr_oe_o; endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write strobe driven in hold");
    // The strobe is a one-period pulse with the address driven under it.
    property p_latch; addr_latch_o |-> ad_oe_o ##1 !addr_latch_o; endproperty
    a_latch: assert property (p_latch) else $error("latch without address");
    // A read strobe must never overlap the lane drive, not even the period before.
    property p_rd_float; !rd_n_o && rd_oe_o |-> !ad_oe_o && !$past(ad_oe_o); endproperty
    a_rd_float: assert property (p_rd_float) else $error("read strobe over driven lane");
    property p_cycle;
        req_valid_i && req_ready_o && !req_word_i |-> ##1 addr_latch_o ##1 !addr_latch_o
            ##3 resp_valid_o;
    endproperty
    a_cycle: assert property (p_cycle) else $error("byte cycle not four periods");
endmodule : ext_bus_port_asserts

/* File: muxed_external_bus_port_bench.sv */
module muxed_external_bus_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ext_bus_pkg::*;
    typedef struct packed {logic w; logic wd; logic io; logic [15:0] a; logic [15:0] d;} row_t;
    logic core_clk_i = 0, resetn_i = 0, clk_en_i = 1, pulldown_en_i = 1, hold_req_i = 0;
    logic req_valid_i = 0, req_write_i = 0, req_word_i = 0, req_io_i = 0;
    logic [15:0] req_addr_i = 0, req_wdata_i = 0, region_base_i = 0, resp_rdata_o;
    logic [7:0] ad_i, ad_o;
    logic [2:0] addr_o;
    logic [5:0] periph_region_select_n_o;
    logic req_ready_o, resp_valid_o, hold_ack_o, ad_oe_o, addr_oe_o, addr_latch_o;
    logic addr_latch_oe_o, addr_latch_pulldown_o, rd_n_o, rd_oe_o, wr_n_o, wr_oe_o;
    int num_errors = 0, checks = 0, n;
    // Word rows check byte order, the last two rows use I/O space.
    row_t rows [7] = '{'{1, 0, 0, 16'h0015, 16'h005A}, '{1, 1, 0, 16'h0026, 16'hC3A7},
        '{0, 0, 0, 16'h0015, 16'h005A}, '{0, 1, 0, 16'h0026, 16'hC3A7},
        '{0, 0, 0, 16'h0027, 16'h00C3}, '{1, 0, 1, 16'h0512, 16'h0033},
        '{0, 0, 1, 16'h0512, 16'h0033}};
    ext_bus_port i_ext_bus_port (.*);
    periph_model i_periph_model (.*);
    always #12.5 core_clk_i = ~core_clk_i;
    task cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e) begin num_errors++; $display("[ERR] %s exp %h got %h", nm, e, s); end
    endtask : cmp
    task end_of_test;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    // Bounded wait at falling edges; running out ends the run.
    task tick;
        @(negedge core_clk_i);
        if (++n > 40) begin num_errors++; end_of_test(); end
    endtask : tick
    // One request held until its first latch pulse, then checked at its pins.
    task xfer(input row_t r);
        logic [15:0] ea;
        logic [5:0] sel;
        ea = r.a;
        sel = '1;
        n = 0;
        {req_write_i, req_word_i, req_io_i, req_addr_i, req_wdata_i} = r;
        req_valid_i = 1;
        do begin
            tick();
            sel &= periph_region_select_n_o;
            if (addr_latch_o) cmp("lane", ea[7:0], ad_o);
            if (addr_latch_o) cmp("addr", ea[2:0], addr_o);
            if (addr_latch_o) begin req_valid_i = 0; ea++; end
        end while (!resp_valid_o);
        if (!r.w) cmp("rdata", r.d, resp_rdata_o);
        cmp("select", r.io ? {10'h000, ~(6'h01 << r.a[15:8])} : 16'h003F, {10'h000, sel});
    endtask : xfer
    initial
    begin
        repeat (20) @(negedge core_clk_i);
        cmp("reset floats", 0, {ad_oe_o, addr_oe_o, wr_oe_o});
        cmp("reset pulldown", 16'h0001, {15'h0000, addr_latch_pulldown_o});
        resetn_i = 1;
        n = 0;
        do tick(); while (!req_ready_o);
        foreach (rows[i]) xfer(rows[i]);
        for (int k = 0; k < 6; k++) xfer({3'b101, 8'(k), 8'h40 + 8'(k), 16'h00AA});
        hold_req_i = 1;
        req_valid_i = 1;
        n = 0;
        do tick(); while (!hold_ack_o);
        repeat (4) tick();
        cmp("hold", 16'h0001, {ad_oe_o, addr_oe_o, rd_oe_o, wr_oe_o, addr_latch_oe_o,
            req_ready_o, addr_latch_o, addr_latch_pulldown_o});
        {hold_req_i, req_valid_i} = 0;
        n = 0;
        do tick(); while (!req_ready_o);
        {req_write_i, req_addr_i, req_valid_i} = {1'b1, 16'h0030, 1'b1};
        n = 0;
        do tick(); while (!addr_latch_o);
        {resetn_i, req_valid_i} = 0;
        #1 cmp("reset mid cycle", 0, {ad_oe_o, addr_oe_o, wr_oe_o});
        tick();
        resetn_i = 1;
        n = 0;
        do tick(); while (!req_ready_o);
        xfer(rows[2]);
        end_of_test();
    end
endmodule : muxed_external_bus_port_bench
bind ext_bus_port ext_bus_port_asserts i_asserts (.*);

/* File: periph_model.sv */
// Byte-wide peripheral on the shared lane.
module periph_model
(
    input wire logic core_clk_i,
    input wire logic [7:0] ad_o,
    input wire logic ad_oe_o,
    input wire logic addr_latch_o,
    input wire logic rd_n_o,
    input wire logic wr_n_o,
    output logic [7:0] ad_i
);
    logic [7:0] mem [256];
    logic [7:0] lat;
    logic [7:0] last = 8'h00;
    logic [7:0] pend;
    // The lane is sampled mid-period while the strobe is high, because the port changes the
    // lane on the very clock edge at which the strobe falls.
    always @(negedge core_clk_i) if (addr_latch_o) pend = ad_o;
    // Address is taken at the falling strobe edge and kept for the cycle.
    always @(negedge addr_latch_o) lat = pend;
    // Data is still driven when the write strobe rises.
    always @(posedge wr_n_o) mem[lat] = ad_o;
    // The lane has no pull, so a released lane toggles instead of keeping old data.
    always @(posedge core_clk_i) last <= ~ad_i;
    assign ad_i = ad_oe_o ? ad_o : (rd_n_o ? last : mem[lat]);
endmodule : periph_model

/* File: pin_sync.sv */
// Three-stage synchroniser; a change counts once stages one and two agree.
module pin_sync
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic pin_i,
    output logic level_o
);
    import ext_bus_pkg::*;
    logic [SYNC_STAGES-1:0] stage;

    // Stage zero feeds only stage one, so a metastable value never reaches logic.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            stage <= '0;
            level_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            stage <= {stage[SYNC_STAGES-2:0], pin_i};
            if (stage[1] == stage[2])
                level_o <= stage[2];
        end
    end
endmodule : pin_sync
